// ==== common/tmsc_burst_if.sv ====
// Purpose: Carrier between the sequencer and the burst pulse generator
// Assumes: One burst in flight at a time
// Notes: start is a one-cycle pulse, done likewise
`timescale 1ns/1ps
`default_nettype none
interface tmsc_burst_if;
  logic start;
  logic [tmsc_pkg::BL_W-1:0] bl;
  logic [tmsc_pkg::DWELL_W-1:0] dwell;
  logic busy;
  logic done;
  logic drive;
  logic capture;
  modport seq (output start, output bl, output dwell, input busy, input done, input drive, input capture);
  modport gen (input start, input bl, input dwell, output busy, output done, output drive, output capture);
endinterface : tmsc_burst_if
`default_nettype wire

// ==== common/tmsc_pkg.sv ====
// Purpose: Shared constants and types for the touch matrix startup calibration block
// Assumes: 50 MHz clock, 24 keys on 8 drive and 3 receive lines
// Notes: Dwell table holds eight window lengths in ns
package tmsc_pkg;
  localparam int CLK_NS = 20;
  localparam int NUM_KEYS = 24;
  localparam int NUM_X = 8;
  localparam int NUM_Y = 3;
  localparam int KEY_W = 5;
  localparam int SAMPLE_W = 12;
  localparam int NIL_W = 8;
  localparam int BL_W = 2;
  localparam int DWELL_W = 3;
  localparam int CNT_W = 6;
  localparam int TMR_W = 23;
  localparam int BTMR_W = 8;
  localparam int PULSE_W = 7;
  // Startup deadline, longest time so rounded down
  localparam int INIT_MAX_MS = 95;
  localparam int INIT_MAX_CYC = (INIT_MAX_MS * 1000000) / CLK_NS;
  // Calibration length in keyscan cycles
  localparam int CAL_MIN_CYC = 11;
  localparam int CAL_MAX_CYC = 62;
  // Convergence band and reference tracking shift
  localparam int CONV_TOL = 2;
  localparam int REF_SHIFT = 2;
  // Pulses per burst step of the burst length setting
  localparam int BURST_UNIT = 16;
  // Drive low phase between pulses
  localparam int X_LOW_NS = 250;
  localparam int X_LOW_CYC = (X_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Dwell window lengths in ns, code 0 to 7
  localparam int DWELL_NS [8] = '{125, 250, 500, 750, 1000, 1500, 2500, 4500};

  // Least time: round up, never below one cycle
  function automatic logic [BTMR_W-1:0] dwell_cyc(input logic [DWELL_W-1:0] code);
    int c;
    c = (DWELL_NS[code] + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return BTMR_W'(c);
  endfunction : dwell_cyc

  typedef enum logic [2:0] {ST_INIT, ST_FAIL, ST_SCAN, ST_BURST, ST_CONV} tmsc_st_t;
  typedef enum logic [1:0] {BS_IDLE, BS_HIGH, BS_LOW} tmsc_bst_t;
endpackage : tmsc_pkg

// ==== hdl/tmsc_burst.sv ====
// Purpose: Burst of drive pulses with a dwell capture window per rising edge
// Assumes: Settings are latched at start
// Notes: Capture window opens on each rising drive edge
`timescale 1ns/1ps
`default_nettype none
module tmsc_burst (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Sequencer side
  tmsc_burst_if.gen bif
);
  typedef struct packed {
    tmsc_pkg::tmsc_bst_t st;
    logic [tmsc_pkg::BTMR_W-1:0] tmr;
    logic [tmsc_pkg::BTMR_W-1:0] dwell;
    logic [tmsc_pkg::PULSE_W-1:0] left;
    logic done;
  } tmsc_bstate_t;

  tmsc_bstate_t q, d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      tmsc_pkg::BS_IDLE: begin
        if (bif.start) begin
          d.dwell = tmsc_pkg::dwell_cyc(bif.dwell);
          d.left = tmsc_pkg::PULSE_W'((32'(bif.bl) + 1) * tmsc_pkg::BURST_UNIT);
          d.tmr = '0;
          d.st = tmsc_pkg::BS_HIGH;
        end
      end
      tmsc_pkg::BS_HIGH: begin
        d.tmr = q.tmr + 1'b1;
        if (q.tmr == q.dwell - 1'b1) begin
          d.tmr = '0;
          d.left = q.left - 1'b1;
          d.st = tmsc_pkg::BS_LOW;
        end
      end
      tmsc_pkg::BS_LOW: begin
        d.tmr = q.tmr + 1'b1;
        if (q.tmr == tmsc_pkg::BTMR_W'(tmsc_pkg::X_LOW_CYC - 1)) begin
          d.tmr = '0;
          if (q.left == '0) begin
            d.done = 1'b1;
            d.st = tmsc_pkg::BS_IDLE;
          end else begin
            d.st = tmsc_pkg::BS_HIGH;
          end
        end
      end
      default: begin
        d.st = tmsc_pkg::BS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: tmsc_pkg::BS_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign bif.busy = (q.st != tmsc_pkg::BS_IDLE);
  assign bif.done = q.done;
  assign bif.drive = (q.st == tmsc_pkg::BS_HIGH);
  assign bif.capture = (q.st == tmsc_pkg::BS_HIGH);
endmodule : tmsc_burst
`default_nettype wire

// ==== hdl/tmsc_top.sv ====
// Purpose: Startup check gate and per-key calibration sequencer for a 24-key matrix
// Assumes: Self-check, charge conversion and host serial logic sit outside
// Notes: One conversion result per burst closes each key slot
// Function
// - Host interface enabled last, only when self-checks pass; faults keep it off.
// - Host interface ready within 95 ms of reset release.
// - Calibration of all enabled keys starts right after initialization, in parallel.
// - Key calibration lasts between 11 and 62 keyscan cycles.
// - Key calibration ends once its reference converges with signal level.
// - Reaching 62 cycles unconverged flags an error for that key.
// - Per-key calibrating status is exposed while calibration runs.
// - Disabled keys are skipped, shortening the keyscan cycle.
// - Dwell window selectable from eight codes, 125 ns to 4.5 us.
// - Charge captured only during dwell window after each rising drive edge.
// - Keys 0 to 23 scanned in order, drive lines within each receive line.
// - Zero integrator limit disables a key for scan and calibration.
`timescale 1ns/1ps
`default_nettype none
module tmsc_top #(
  parameter int INIT_TMO_CYC = tmsc_pkg::INIT_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Self-check results
  input wire logic selfcheck_done_i,
  input wire logic selfcheck_pass_i,
  input wire logic safety_fault_i,
  // Host interface gate
  output logic host_if_en_o,
  output logic init_fail_o,
  // Per-key setups and the shared dwell code
  input wire logic [tmsc_pkg::NUM_KEYS-1:0][tmsc_pkg::NIL_W-1:0] normal_integrator_limit_i,
  input wire logic [tmsc_pkg::NUM_KEYS-1:0][tmsc_pkg::BL_W-1:0] burst_length_setting_i,
  input wire logic [tmsc_pkg::DWELL_W-1:0] dwell_code_i,
  // Matrix drive and capture
  output logic [tmsc_pkg::NUM_X-1:0] x_drive_o,
  output logic [tmsc_pkg::NUM_Y-1:0] y_capture_o,
  // Charge conversion
  output logic conv_req_o,
  output logic [tmsc_pkg::KEY_W-1:0] conv_key_o,
  input wire logic sample_valid_i,
  input wire logic [tmsc_pkg::SAMPLE_W-1:0] sample_i,
  // Calibration status
  output logic [tmsc_pkg::NUM_KEYS-1:0] cal_active_o,
  output logic [tmsc_pkg::NUM_KEYS-1:0] cal_error_o,
  output logic calibrating_o
);
  typedef struct packed {
    tmsc_pkg::tmsc_st_t st;
    logic [tmsc_pkg::TMR_W-1:0] tmr;
    logic host_en;
    logic fail;
    logic [tmsc_pkg::KEY_W-1:0] key;
    logic burst_go;
    logic [tmsc_pkg::NUM_KEYS-1:0] cal;
    logic [tmsc_pkg::NUM_KEYS-1:0] err;
    logic [tmsc_pkg::NUM_KEYS-1:0][tmsc_pkg::CNT_W-1:0] cnt;
    logic [tmsc_pkg::NUM_KEYS-1:0][tmsc_pkg::SAMPLE_W-1:0] refv;
  } tmsc_state_t;

  tmsc_state_t q, d;
  logic [tmsc_pkg::NUM_KEYS-1:0] key_en;
  logic [tmsc_pkg::KEY_W-1:0] first_key;
  logic [tmsc_pkg::KEY_W-1:0] after_key;
  logic signed [tmsc_pkg::SAMPLE_W:0] diff;
  logic [tmsc_pkg::SAMPLE_W:0] mag;
  logic [tmsc_pkg::CNT_W-1:0] cnt_nx;
  logic [tmsc_pkg::SAMPLE_W-1:0] ref_nx;
  logic [2:0] x_sel;
  logic [1:0] y_sel;

  tmsc_burst_if bif ();

  // Next enabled key after k, wrapping past key 23
  function automatic logic [tmsc_pkg::KEY_W-1:0] next_key(
    input logic [tmsc_pkg::KEY_W-1:0] k,
    input logic [tmsc_pkg::NUM_KEYS-1:0] en
  );
    logic [tmsc_pkg::KEY_W-1:0] res;
    logic found;
    int idx;
    res = k;
    found = 1'b0;
    for (int i = 1; i <= tmsc_pkg::NUM_KEYS; i++) begin
      idx = (int'(k) + i) % tmsc_pkg::NUM_KEYS;
      if (!found && en[idx]) begin
        res = tmsc_pkg::KEY_W'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_key

  generate
    for (genvar g = 0; g < tmsc_pkg::NUM_KEYS; g++) begin : g_en
      assign key_en[g] = (normal_integrator_limit_i[g] != '0);
    end
  endgenerate

  assign first_key = next_key(tmsc_pkg::KEY_W'(tmsc_pkg::NUM_KEYS - 1), key_en);
  assign after_key = next_key(q.key, key_en);

  // Reference tracking for the key under conversion
  always_comb begin
    diff = $signed({1'b0, sample_i}) - $signed({1'b0, q.refv[q.key]});
    mag = diff[tmsc_pkg::SAMPLE_W] ? $unsigned(-diff) : $unsigned(diff);
    cnt_nx = q.cnt[q.key] + 1'b1;
    // First sample seeds the reference, later ones pull it in
    if (q.cnt[q.key] == '0) begin
      ref_nx = sample_i;
    end else begin
      ref_nx = tmsc_pkg::SAMPLE_W'($signed(q.refv[q.key]) + (diff >>> tmsc_pkg::REF_SHIFT));
    end
  end

  always_comb begin
    d = q;
    d.burst_go = 1'b0;
    d.cal = q.cal & key_en;
    case (q.st)
      tmsc_pkg::ST_INIT: begin
        d.tmr = q.tmr + 1'b1;
        if (safety_fault_i || (selfcheck_done_i && !selfcheck_pass_i)) begin
          d.fail = 1'b1;
          d.st = tmsc_pkg::ST_FAIL;
        end else if (q.tmr >= tmsc_pkg::TMR_W'(INIT_TMO_CYC - 1)) begin
          d.fail = 1'b1;
          d.st = tmsc_pkg::ST_FAIL;
        end else if (selfcheck_done_i) begin
          d.host_en = 1'b1;
          d.cal = key_en;
          d.err = '0;
          d.cnt = '0;
          d.key = first_key;
          d.st = tmsc_pkg::ST_SCAN;
        end
      end
      tmsc_pkg::ST_FAIL: begin
        d.host_en = 1'b0;
      end
      tmsc_pkg::ST_SCAN: begin
        if (key_en[q.key]) begin
          d.burst_go = 1'b1;
          d.st = tmsc_pkg::ST_BURST;
        end else begin
          d.key = after_key;
        end
      end
      tmsc_pkg::ST_BURST: begin
        if (bif.done) begin
          d.st = tmsc_pkg::ST_CONV;
        end
      end
      tmsc_pkg::ST_CONV: begin
        if (sample_valid_i) begin
          if (q.cal[q.key]) begin
            d.cnt[q.key] = cnt_nx;
            d.refv[q.key] = ref_nx;
            if (mag <= tmsc_pkg::CONV_TOL && cnt_nx >= tmsc_pkg::CNT_W'(tmsc_pkg::CAL_MIN_CYC)) begin
              d.cal[q.key] = 1'b0;
            end else if (cnt_nx >= tmsc_pkg::CNT_W'(tmsc_pkg::CAL_MAX_CYC)) begin
              d.cal[q.key] = 1'b0;
              d.err[q.key] = 1'b1;
            end
          end
          d.key = after_key;
          d.st = tmsc_pkg::ST_SCAN;
        end
      end
      default: begin
        d.st = tmsc_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: tmsc_pkg::ST_INIT, default: '0};
    end else begin
      q <= d;
    end
  end

  assign bif.start = q.burst_go;
  assign bif.bl = burst_length_setting_i[q.key];
  assign bif.dwell = dwell_code_i;

  tmsc_burst u_burst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bif(bif)
  );

  // Key number splits into drive line and receive line
  assign x_sel = q.key[2:0];
  assign y_sel = q.key[4:3];

  always_comb begin
    x_drive_o = '0;
    y_capture_o = '0;
    if (q.st == tmsc_pkg::ST_BURST) begin
      x_drive_o[x_sel] = bif.drive;
      if (y_sel < 2'(tmsc_pkg::NUM_Y)) begin
        y_capture_o[y_sel] = bif.capture;
      end
    end
  end

  assign host_if_en_o = q.host_en;
  assign init_fail_o = q.fail;
  assign conv_req_o = (q.st == tmsc_pkg::ST_CONV);
  assign conv_key_o = q.key;
  assign cal_active_o = q.cal;
  assign cal_error_o = q.err;
  assign calibrating_o = |q.cal;
endmodule : tmsc_top
`default_nettype wire

// ==== tb/test_tmsc_top.sv ====
// Purpose: Self-checking bench for tmsc_top
// Assumes: Deadline cut to 200 cycles
// Notes: Short bursts bound the 62-scan run
`timescale 1ns/1ps
`default_nettype none
module test_tmsc_top;
  localparam int TMO = 200;
  logic clk_i = 0, resetn_i = 0, selfcheck_done_i = 0, selfcheck_pass_i = 0, safety_fault_i = 0;
  logic host_if_en_o, init_fail_o, conv_req_o, sample_valid_i, calibrating_o, req_q;
  logic [23:0][7:0] nil = '0;
  logic [23:0][1:0] bl = '0;
  logic [2:0] dwell_code_i = '0, y_capture_o;
  logic [7:0] x_drive_o;
  logic [4:0] conv_key_o, last;
  logic [11:0] sample_i, level = 12'h0100;
  logic [23:0] cal_active_o, cal_error_o, en, act_q = '0, noisy = '0;
  logic [31:0] rs = 32'heb3e_b149;
  int n_fail = 0, n_checks = 0;
  int cnt [24];
  tmsc_top #(.INIT_TMO_CYC(TMO)) i_tmsc_top (.*, .normal_integrator_limit_i(nil), .burst_length_setting_i(bl));
  tmsc_conv_model i_tmsc_conv_model (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(conv_req_o), .key_i(conv_key_o),
    .noisy_i(noisy), .level_i(level), .valid_o(sample_valid_i), .data_o(sample_i));
  always_comb begin
    for (int k = 0; k < 24; k++) begin
      en[k] = |nil[k];
    end
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [4:0] nxt(input logic [4:0] k);
    for (int i = 1; i <= 24; i++) begin
      if (en[(k + i) % 24]) begin
        return 5'((k + i) % 24);
      end
    end
    return k;
  endfunction : nxt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic start(input logic ok, input logic flt, input int dly);
    resetn_i = 0;
    selfcheck_done_i = 0;
    safety_fault_i = flt;
    selfcheck_pass_i = ok;
    // Clear once requests have dropped, so the monitor cannot race
    @(negedge clk_i);
    cnt = '{default: 0};
    last = 23;
    repeat (19) @(negedge clk_i);
    resetn_i = 1;
    repeat (dly) @(negedge clk_i);
    selfcheck_done_i = 1;
    repeat (2) @(negedge clk_i);
  endtask : start
  always @(negedge clk_i) begin
    if (conv_req_o && !req_q) begin
      chk(conv_key_o, nxt(last), "scan order");
    end
    if (conv_req_o && sample_valid_i) begin
      cnt[conv_key_o]++;
      last = conv_key_o;
    end
    for (int k = 0; k < 24; k++) begin
      if (resetn_i && act_q[k] && !cal_active_o[k]) begin
        chk(cnt[k], noisy[k] ? 62 : 11, "cal length");
      end
    end
    req_q = conv_req_o;
    act_q = cal_active_o;
  end
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  initial begin
    start(1, 1, 3);
    chk({host_if_en_o, init_fail_o}, 2'b01, "fault");
    start(0, 0, 3);
    chk({host_if_en_o, init_fail_o}, 2'b01, "check fail");
    start(1, 0, TMO + 5);
    chk({host_if_en_o, init_fail_o}, 2'b01, "deadline");
    for (int c = 0; c < 8; c++) begin
      dwell_code_i = 3'(c);
      nil = '0;
      bl = 48'(rnd());
      nil[rnd() % 24] = 8'(rnd() | 1);
      start(1, 0, 3);
      chk({host_if_en_o, init_fail_o}, 2'b10, "enable");
      chk(cal_active_o, en, "cal start");
      repeat (600) @(negedge clk_i);
    end
    // Wrap past key 23, one key never settles
    dwell_code_i = '0;
    bl = '0;
    nil = '0;
    level = 12'(rnd());
    nil[rnd() % 12] = 8'h01;
    noisy = 24'(1) << (12 + rnd() % 11);
    nil[12 + $clog2(noisy) - 12] = 8'hff;
    nil[23] = 8'(rnd() | 1);
    start(1, 0, 3);
    for (int i = 0; i < 70000 && calibrating_o !== 1'b0; i++) begin
      @(negedge clk_i);
    end
    // Loop limit running out is a mismatch too
    chk(calibrating_o, 1'b0, "cal timeout");
    chk(cal_error_o, noisy, "cal errors");
    finish_test();
  end
endmodule : test_tmsc_top
`default_nettype wire

// ==== tb/tmsc_conv_model.sv ====
// Purpose: Conversion stand-in answering conv_req_o
// Assumes: One request at a time
// Notes: Noisy keys swing wide and never settle
`timescale 1ns/1ps
`default_nettype none
module tmsc_conv_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Request
  input wire logic req_i,
  input wire logic [4:0] key_i,
  input wire logic [23:0] noisy_i,
  input wire logic [11:0] level_i,
  // Result
  output logic valid_o,
  output logic [11:0] data_o
);
  int wait_q;
  logic [23:0] flip_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 0;
      flip_q <= '0;
      valid_o <= 1'b0;
      data_o <= 12'h0000;
    end else if (req_i && !valid_o && wait_q >= 3 * key_i[1:0]) begin
      // Prompt or slow, by key
      valid_o <= 1'b1;
      flip_q[key_i] <= !flip_q[key_i];
      data_o <= noisy_i[key_i] ? {flip_q[key_i], 11'h7a0} : level_i + 12'(key_i);
    end else begin
      // Idle data toggles, no stale value
      valid_o <= 1'b0;
      data_o <= ~data_o;
      wait_q <= (req_i && !valid_o) ? wait_q + 1 : 0;
    end
  end
endmodule : tmsc_conv_model
`default_nettype wire

// ==== tb/tmsc_top_asserts.sv ====
// Purpose: Port checks for tmsc_top
// Assumes: One clock, reset active low
// Notes: Dwell widths from the package table
`timescale 1ns/1ps
`default_nettype none
module tmsc_top_asserts #(
  parameter int INIT_TMO_CYC = 200
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Startup
  input wire logic selfcheck_done_i,
  input wire logic selfcheck_pass_i,
  input wire logic safety_fault_i,
  input wire logic host_if_en_o,
  input wire logic init_fail_o,
  // Scan
  input wire logic [23:0][7:0] normal_integrator_limit_i,
  input wire logic [2:0] dwell_code_i,
  input wire logic [7:0] x_drive_o,
  input wire logic [2:0] y_capture_o,
  input wire logic [4:0] conv_key_o,
  input wire logic [23:0] cal_active_o,
  input wire logic calibrating_o
);
  int t_q;
  int hw_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      t_q <= 0;
      hw_q <= 0;
    end else begin
      t_q <= (t_q < INIT_TMO_CYC) ? t_q + 1 : t_q;
      hw_q <= (|x_drive_o) ? hw_q + 1 : 0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_idle;
    !host_if_en_o && !init_fail_o && t_q < INIT_TMO_CYC - 1;
  endsequence
  sequence s_bad;
    safety_fault_i || (selfcheck_done_i && !selfcheck_pass_i);
  endsequence
  sequence s_good;
    selfcheck_done_i && selfcheck_pass_i && !safety_fault_i;
  endsequence
  pass_enables_a: assert property (s_idle ##0 s_good |=> host_if_en_o)
    else $error("no enable after pass");
  fault_blocks_a: assert property (s_idle ##0 s_bad |=> init_fail_o && !host_if_en_o)
    else $error("enable after failed check");
  host_stays_a: assert property (host_if_en_o |=> host_if_en_o && !init_fail_o)
    else $error("enable not steady");
  init_deadline_a: assert property (t_q >= INIT_TMO_CYC |-> host_if_en_o || init_fail_o)
    else $error("startup past deadline");
  cal_status_a: assert property (calibrating_o == |cal_active_o)
    else $error("status flag mismatch");
  drive_key_a: assert property (|x_drive_o |-> normal_integrator_limit_i[conv_key_o] != 0
    && x_drive_o == 8'(1) << conv_key_o[2:0] && y_capture_o == 3'(1) << conv_key_o[4:3])
    else $error("wrong line driven");
  capture_in_drive_a: assert property ((|y_capture_o) == (|x_drive_o))
    else $error("capture outside drive");
  dwell_width_a: assert property ($fell(|x_drive_o) |-> hw_q == (tmsc_pkg::DWELL_NS[dwell_code_i] + 19) / 20)
    else $error("dwell width wrong");
endmodule : tmsc_top_asserts
bind tmsc_top tmsc_top_asserts #(.INIT_TMO_CYC(INIT_TMO_CYC)) i_tmsc_top_asserts (.*);
`default_nettype wire
